/* File: core/wit_consts.svh */
// constants of the watch and interval timer: register offset, fields, reset value, counts
`ifndef WIT_CONSTS_SVH
`define WIT_CONSTS_SVH
`define WIT_MODE_ADDR       16'hFF41
`define WIT_MODE_RESET      8'h00
`define WIT_BIT_CLK_SRC     7
`define WIT_FLD_IVL_HI      6
`define WIT_FLD_IVL_LO      4
`define WIT_BIT_FAST        3
`define WIT_BIT_SELECT      2
`define WIT_BIT_CNT_EN      1
`define WIT_BIT_PRE_EN      0
`define WIT_MAIN_DIV        256
`define WIT_PRE_WIDTH       9
`define WIT_CNT_WIDTH       5
`define WIT_IVL_MAX         3'h5
`define WIT_IVL_BASE_TAP    4
`define WIT_FAST_TAP        5
`define WIT_SEL_BASE_STAGE  0
`endif

/* File: core/wit_pkg.sv */
// types of the watch and interval timer
package wit_pkg;
	typedef struct packed {
		logic       clock_source_sel;
		logic [2:0] interval_sel;
		logic       fast_feed_sel;
		logic       selectable_interval_sel;
		logic       counter_enable;
		logic       prescaler_enable;
	} wit_mode_s;

	typedef struct packed {
		logic        wr;
		logic        bit_wr;
		logic [2:0]  bit_idx;
		logic        bit_val;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} wit_cpu_req_s;

	typedef struct packed {
		logic       watch_irq;
		logic       interval_irq;
	} wit_irq_s;
endpackage : wit_pkg

/* File: core/wit_timer.sv */
// watch timer: mode register, 9-bit prescaler, 5-bit counter, two interrupt pulses
`include "wit_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module wit_timer #(
	parameter int unsigned MAIN_DIV = `WIT_MAIN_DIV
) (
	input  wire logic               i_clock,
	input  wire logic               i_rst_n,
	input  wire logic               i_clk_en,
	input  wire logic               i_sub_clock,
	input  wire wit_pkg::wit_cpu_req_s i_cpu,
	output logic [7:0]              o_watch_mode_reg,
	output wit_pkg::wit_irq_s       o_irq
);
	import wit_pkg::*;

	// ------------------------------------------------------------
	// sizes
	// ------------------------------------------------------------
	localparam int          PW       = `WIT_PRE_WIDTH;
	localparam int          CW       = `WIT_CNT_WIDTH;
	localparam int          NUM_IVL  = int'(`WIT_IVL_MAX) + 1;
	localparam int          IVL_BASE = `WIT_IVL_BASE_TAP;
	localparam int          FAST_TAP = `WIT_FAST_TAP;
	localparam logic [15:0] DIV_LAST = 16'(MAIN_DIV - 1);

	// ------------------------------------------------------------
	// elaboration checks
	// ------------------------------------------------------------
	// the divider is a 16-bit counter, and a divide by one would turn every cycle into a tick
	if (MAIN_DIV < 2 || MAIN_DIV > 65536) begin : g_bad_main_div
		$error("MAIN_DIV must lie between 2 and 65536");
	end

	// the highest interval tap must still fall inside the prescaler
	if (IVL_BASE + NUM_IVL - 1 > PW) begin : g_bad_ivl_taps
		$error("interval taps reach beyond the prescaler");
	end

	// fast feed is taken from the prescaler alone
	if (FAST_TAP > PW) begin : g_bad_fast_tap
		$error("fast feed tap reaches beyond the prescaler");
	end

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		wit_mode_s     mode;
		logic [15:0]   div;
		logic [2:0]    sub_sync;
		logic [PW-1:0] pre;
		logic [CW-1:0] cnt;
		wit_irq_s      irq;
	} wit_state_s;

	wit_state_s state_q;
	wit_state_s state_d;

	// ------------------------------------------------------------
	// helper signals
	// ------------------------------------------------------------
	logic               reg_hit;
	logic               main_tick;
	logic               sub_tick;
	logic               tick;
	logic [PW:0]        pre_inc;
	logic [CW:0]        cnt_inc;
	logic               carry_out;
	logic [NUM_IVL-1:0] ivl_tap;
	logic               ivl_wrap;
	logic [2:0]         sel_stage;
	logic               fast_wrap;
	logic               cnt_wrap;
	logic               watch_wrap;
	logic               watch_gate;

	// ------------------------------------------------------------
	// functions
	// ------------------------------------------------------------
	// true when the lowest n bits are all zero, so a 2^n tap has just wrapped
	function automatic logic low_zero(input logic [PW:0] value, input int unsigned n);
		logic all_zero;
		all_zero = 1'b1;
		for (int unsigned b = 0; b <= PW; b++) begin
			if (b < n && value[b])
				all_zero = 1'b0;
		end
		return all_zero;
	endfunction : low_zero

	// stage that ends a watch period: 0 is the prescaler carry (2^9), s adds s counter bits (2^(9+s))
	function automatic logic [2:0] watch_stage(input wit_mode_s m);
		logic [2:0] stage;
		stage = 3'h5;
		if (m.selectable_interval_sel && m.interval_sel != `WIT_IVL_MAX)
			stage = m.interval_sel;
		return stage;
	endfunction : watch_stage

	// ------------------------------------------------------------
	// register access
	// ------------------------------------------------------------
	assign reg_hit = i_cpu.wr && (i_cpu.addr == `WIT_MODE_ADDR);

	// ------------------------------------------------------------
	// watch clock
	// ------------------------------------------------------------
	// the sub clock pin is foreign: two flops, then the edge is taken from the second and third only
	assign main_tick = (state_q.div == DIV_LAST);
	assign sub_tick  = state_q.sub_sync[1] & ~state_q.sub_sync[2];
	assign tick      = state_q.mode.clock_source_sel ? sub_tick : main_tick;

	// ------------------------------------------------------------
	// prescaler and counter increments
	// ------------------------------------------------------------
	assign pre_inc   = {1'b0, state_q.pre} + {{PW{1'b0}}, 1'b1};
	assign cnt_inc   = {1'b0, state_q.cnt} + {{CW{1'b0}}, 1'b1};
	assign carry_out = pre_inc[PW];

	// ------------------------------------------------------------
	// interval taps
	// ------------------------------------------------------------
	// tap g is 2^(g+4) watch clock ticks
	for (genvar g = 0; g < NUM_IVL; g++) begin : g_ivl_tap
		assign ivl_tap[g] = low_zero(pre_inc, IVL_BASE + g);
	end

	// prohibited codes give no interval request at all
	assign ivl_wrap = (state_q.mode.interval_sel < 3'(NUM_IVL)) ? ivl_tap[state_q.mode.interval_sel] : 1'b0;

	// ------------------------------------------------------------
	// watch interval
	// ------------------------------------------------------------
	assign sel_stage  = watch_stage(state_q.mode);
	assign fast_wrap  = low_zero(pre_inc, FAST_TAP);
	assign cnt_wrap   = low_zero({{(PW + 1 - CW){1'b0}}, cnt_inc[CW-1:0]}, int'(sel_stage));
	assign watch_wrap = state_q.mode.fast_feed_sel ? fast_wrap : (carry_out && cnt_wrap);

	// fast feed needs no counter; every other interval counts prescaler carries
	assign watch_gate = state_q.mode.fast_feed_sel || state_q.mode.counter_enable;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		logic [7:0] mode_next;
		mode_next = state_q.mode;
		state_d   = state_q;

		if (reg_hit) begin
			if (i_cpu.bit_wr) begin
				mode_next[i_cpu.bit_idx] = i_cpu.bit_val;
			end else begin
				mode_next = i_cpu.wdata;
			end
		end
		state_d.mode = wit_mode_s'(mode_next);

		state_d.sub_sync = {state_q.sub_sync[1:0], i_sub_clock};

		// the divider runs free, so switching back to the main clock never waits for a restart
		if (main_tick) begin
			state_d.div = 16'h0000;
		end else begin
			state_d.div = state_q.div + 16'h0001;
		end

		state_d.irq = '0;
		if (!state_q.mode.prescaler_enable) begin
			state_d.pre = '0;
		end else if (tick) begin
			state_d.pre              = pre_inc[PW-1:0];
			state_d.irq.interval_irq = ivl_wrap;
			state_d.irq.watch_irq    = watch_wrap && watch_gate;
		end

		if (!state_q.mode.counter_enable) begin
			state_d.cnt = '0;
		end else if (state_q.mode.prescaler_enable && tick && carry_out) begin
			state_d.cnt = cnt_inc[CW-1:0];
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_q <= '0;
		end else if (i_clk_en) begin
			state_q <= state_d;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign o_watch_mode_reg = state_q.mode;
	assign o_irq            = state_q.irq;
endmodule : wit_timer

`default_nettype wire

/* File: dv/wit_timer_monitor.sv */
// checker of the watch timer port behaviour
`timescale 1ns/1ps
`default_nettype none
`include "wit_consts.svh"
module wit_timer_monitor import wit_pkg::*; #(parameter int unsigned MAIN_DIV = 256) (
	input wire logic         i_clock,
	input wire logic         i_rst_n,
	input wire logic         i_clk_en,
	input wire logic         i_sub_clock,
	input wire wit_cpu_req_s i_cpu,
	input wire logic [7:0]   o_watch_mode_reg,
	input wire wit_irq_s     o_irq
);
	wire hit = i_clk_en && i_cpu.wr && i_cpu.addr == `WIT_MODE_ADDR;
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);
	// ----------
	// assertions
	// ----------
	a_byte_write: assert property (hit && !i_cpu.bit_wr |=> o_watch_mode_reg == $past(i_cpu.wdata))
		else $error("byte write");
	a_bit_write: assert property (hit && i_cpu.bit_wr |=> o_watch_mode_reg[$past(i_cpu.bit_idx)] == $past(i_cpu.bit_val))
		else $error("bit write");
	a_write_hold: assert property (!hit |=> $stable(o_watch_mode_reg)) else $error("mode moved");
	a_watch_pulse: assert property (o_irq.watch_irq && i_clk_en |=> !o_irq.watch_irq) else $error("watch pulse");
	a_ivl_gap: assert property (o_irq.interval_irq && i_clk_en |=> !o_irq.interval_irq [*8])
		else $error("interval pulse");
	a_pre_stop: assert property (!o_watch_mode_reg[0] [*3] |-> o_irq == '0) else $error("stopped irq");
	a_cnt_stop: assert property ((!o_watch_mode_reg[1] && !o_watch_mode_reg[3]) [*3] |-> !o_irq.watch_irq)
		else $error("counter irq");
	a_bad_code: assert property ((o_watch_mode_reg[6:4] > 3'h5) [*3] |-> !o_irq.interval_irq) else $error("bad code");
	cover property (o_irq.watch_irq && o_watch_mode_reg[3]);
	cover property (o_irq.interval_irq && o_watch_mode_reg[7]);
	cover property (hit && i_cpu.bit_wr);
endmodule : wit_timer_monitor
bind wit_timer wit_timer_monitor #(.MAIN_DIV(MAIN_DIV)) wit_timer_monitor_i (.i_clock(i_clock), .i_rst_n(i_rst_n),
	.i_clk_en(i_clk_en), .i_sub_clock(i_sub_clock), .i_cpu(i_cpu), .o_watch_mode_reg(o_watch_mode_reg), .o_irq(o_irq));
`default_nettype wire

/* File: dv/watch_interval_timer_tb_top.sv */
// self-checking bench of the watch timer
`timescale 1ns/1ps
`default_nettype none
`include "wit_consts.svh"
module watch_interval_timer_tb_top;
	import wit_pkg::*;
	localparam int D = 2;
	logic         i_clock = 0, i_rst_n = 0, i_sub_clock = 0, i_clk_en = 1;
	wit_cpu_req_s i_cpu = '0;
	logic [7:0]   o_watch_mode_reg, em = 8'h00, qm[$];
	wit_irq_s     o_irq;
	int           failures = 0, num_checks = 0;
	logic [31:0]  cyc = 0, lt[2], qg[2][$];
	wit_timer #(.MAIN_DIV(D)) wit_timer_i (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_clk_en(i_clk_en),
		.i_sub_clock(i_sub_clock), .i_cpu(i_cpu), .o_watch_mode_reg(o_watch_mode_reg), .o_irq(o_irq));
	initial forever #12.5 i_clock = ~i_clock;
	always @(posedge i_clock) cyc <= cyc + 1;
	// ---------------
	// drivers, checks
	// ---------------
	// subsystem clock free-runs at one eighth of the system clock
	always begin repeat (4) @(posedge i_clock); i_sub_clock <= ~i_sub_clock; end
	task automatic chk(string n, logic [31:0] s, logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			failures++;
			$display("[ERR] %s exp %0h got %0h", n, e, s);
		end
	endtask : chk
	task automatic end_of_test;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_of_test
	task automatic wr(logic [15:0] a, logic [7:0] d, logic b = 0, logic [2:0] x = 0);
		@(posedge i_clock);
		i_cpu <= '{1'b1, b, x, d[0], a, d};
		@(posedge i_clock);
		i_cpu.wr <= 1'b0;
		if (a == `WIT_MODE_ADDR && b) em[x] = d[0];
		else if (a == `WIT_MODE_ADDR) em = d;
		qm.push_back(em);
	endtask : wr
	task automatic pw(int s);
		int t = 0;
		do @(negedge i_clock); while (o_irq[s] !== 1'b1 && ++t < 70000);
		if (t >= 70000) chk("pulse", 0, 1);
	endtask : pw
	// stop first, so a new interval never meets a running prescaler
	task automatic run(logic [7:0] m, int s, logic [31:0] e);
		wr(`WIT_MODE_ADDR, 8'h00);
		wr(`WIT_MODE_ADDR, m);
		pw(s);
		@(posedge i_clock);
		qg[s].push_back(e);
		pw(s);
	endtask : run
	always @(negedge i_clock) if (qm.size() > 0) chk("mode", o_watch_mode_reg, qm.pop_front());
	always @(negedge i_clock)
		for (int s = 0; s < 2; s++)
			if (o_irq[s] === 1'b1) begin
				if (qg[s].size() > 0) chk("gap", cyc - lt[s], qg[s].pop_front());
				lt[s] = cyc;
			end
	initial begin
		void'($urandom(32'hDEB1EEC8));
		qm.push_back(8'h00);
		repeat (8) @(posedge i_clock);
		i_rst_n <= 1'b1;
		repeat (4) wr(`WIT_MODE_ADDR, 8'($urandom) & 8'hFC);
		wr(16'hFF41 ^ 16'(1 << ($urandom % 16)), 8'($urandom));
		for (int i = 0; i < 8; i++) wr(`WIT_MODE_ADDR, {7'h00, ~em[i]}, 1'b1, 3'(i));
		@(posedge i_clock);
		i_rst_n <= 1'b0;
		em = 8'h00;
		qm.push_back(em);
		repeat (2) @(posedge i_clock);
		i_rst_n <= 1'b1;
		for (int k = 0; k < 6; k++) run({1'b0, 3'(k), 4'h1}, 0, 32'(16 << k) * D);
		run(8'h09, 1, 32 * D);
		run(8'h09, 0, 16 * D);
		for (int k = 0; k < 2; k++) run({1'b0, 3'(k), 4'h7}, 1, 32'(512 << k) * D);
		run(8'h03, 1, 16384 * D);
		run(8'h81, 0, 16 * 8);
		wr(`WIT_MODE_ADDR, 8'h00);
		@(posedge i_clock);
		i_clk_en <= 1'b0;
		i_cpu <= '{1'b1, 1'b0, 3'h0, 1'b0, `WIT_MODE_ADDR, 8'hA5};
		@(posedge i_clock);
		i_cpu.wr <= 1'b0;
		qm.push_back(em);
		@(posedge i_clock);
		i_clk_en <= 1'b1;
		wr(`WIT_MODE_ADDR, 8'h63);
		repeat (300) @(posedge i_clock);
		end_of_test();
	end
	initial begin
		#(25 * 90000);
		chk("watchdog", 0, 1);
		end_of_test();
	end
endmodule : watch_interval_timer_tb_top
`default_nettype wire
